// [logic/vdcs_map.svh]
// register offsets, field positions, reset values and counts of the decoder control bank
`ifndef VDCS_MAP_SVH
`define VDCS_MAP_SVH
// ----------------------------------------------------------------
// register offsets (printed offsets are indices, address = 4 * index)
// ----------------------------------------------------------------
`define VDCS_IDX_IDENT 8'h00
`define VDCS_IDX_STATUS 8'h01
`define VDCS_IDX_INPUT_FORMAT 8'h02
`define VDCS_IDX_RSVD_A 8'h03
`define VDCS_IDX_KILLER 8'h04
`define VDCS_IDX_RSVD_B 8'h05
`define VDCS_IDX_ANALOG 8'h06
`define VDCS_IDX_CROP 8'h07
`define VDCS_IDX_VDLY 8'h08
`define VDCS_IDX_VACT 8'h09
`define VDCS_IDX_HDLY 8'h0a
`define VDCS_IDX_HACT 8'h0b
`define VDCS_IDX_FILT 8'h0c
`define VDCS_IDX_STDSEL 8'h0d
`define VDCS_IDX_MISC 8'h0e
`define VDCS_IDX_LAST 8'h0e
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VDCS_ST_ABSENT 7
`define VDCS_ST_HORIZ_LOOP_LOCKED 6
`define VDCS_ST_SUBCARRIER_LOCKED 5
`define VDCS_ST_FIELD 4
`define VDCS_ST_VERTICAL_LOCKED 3
`define VDCS_ST_NOBURST 1
`define VDCS_ST_FIFTY 0
`define VDCS_AN_RESTART 7
`define VDCS_AN_GAINOFF 4
`define VDCS_STD_SHADOW_OFF 3
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VDCS_RST_INPUT_FORMAT 8'h40
`define VDCS_RST_KILLER 8'h00
`define VDCS_RST_ANALOG 8'h40
`define VDCS_RST_CROP 8'h12
`define VDCS_RST_VDLY 8'h12
`define VDCS_RST_VACT 8'h20
`define VDCS_RST_HDLY 8'h10
`define VDCS_RST_HACT 8'hd0
`define VDCS_RST_FILT 8'hcc
`define VDCS_RST_STDSEL 8'h0f
`define VDCS_RST_MISC 8'h44
`define VDCS_RST_GAIN 9'h0f0
// ----------------------------------------------------------------
// standard codes and counts
// ----------------------------------------------------------------
`define VDCS_STD_PAL 3'h1
`define VDCS_STD_SECAM 3'h2
`define VDCS_STD_PALM 3'h4
`define VDCS_STD_PALCN 3'h5
`define VDCS_STD_PAL60 3'h6
`define VDCS_STD_AUTO 3'h7
`define VDCS_RESTART_CYCLES 4'h4
`endif

// [logic/vdcs_pkg.sv]
// types of the decoder control bank
package vdcs_pkg;
  typedef enum logic [1:0] {
    VDCS_COMPOSITE = 2'h0,
    VDCS_SVIDEO = 2'h1,
    VDCS_COMP_INTL = 2'h2,
    VDCS_COMP_PROG = 2'h3
  } vdcs_decode_type;
  typedef enum logic [2:0] {
    VDCS_RUN = 3'h1,
    VDCS_RESTART = 3'h2,
    VDCS_SETTLE = 3'h4
  } vdcs_phase_type;
  // apb request fields
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } vdcs_apb_req_type;
  // status reported by the decoder core
  typedef struct packed {
    logic video_absent;
    logic horiz_loop_locked;
    logic subcarrier_locked;
    logic field_even;
    logic vertical_locked;
    logic no_burst_flag;
    logic fifty_hz_flag;
  } vdcs_status_type;
  // crop window seen by the core
  typedef struct packed {
    logic [9:0] vert_delay_lines;
    logic [9:0] vert_active_lines;
    logic [9:0] horiz_delay_pixels;
    logic [9:0] horiz_active_pixels;
  } vdcs_window_type;
  // all state of the bank
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] input_format;
    logic [7:0] killer;
    logic [7:0] analog;
    logic [7:0] filt;
    logic [7:0] stdsel;
    logic [7:0] misc;
    logic [8:0] gain;
    logic [1:0] vdly_hi;
    logic [7:0] vdly_lo;
    logic [9:0] vact;
    logic [9:0] vact_50;
    logic [9:0] hdly;
    logic [9:0] hdly_pal;
    logic [9:0] hdly_secam;
    logic [1:0] hact_hi;
    logic [7:0] hact_lo;
    vdcs_phase_type phase;
    logic [3:0] restart_cnt;
    logic core_restart;
    logic gain_loop_run;
    logic [8:0] gain_applied;
    logic [4:0] sleep_vec;
    vdcs_window_type window;
  } vdcs_state_type;
endpackage

// [logic/vdcs_regs.sv]
// apb register bank controlling the analog video decoder front end
`timescale 1ns/100ps
`include "vdcs_map.svh"

module vdcs_regs #(
  parameter logic [4:0] PRODUCT_CODE = 5'h15, // arbitrary value
  parameter logic [2:0] REVISION = 3'h2 // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vdcs_pkg::vdcs_status_type core_status,
  output vdcs_pkg::vdcs_window_type crop_window,
  output logic xtal_freq_sel,
  output logic [1:0] decode_input_type,
  output logic [1:0] luma_source_sel,
  output logic [1:0] killer_time_const,
  output logic core_restart,
  output logic gain_loop_run,
  output logic [8:0] fixed_gain_value,
  output logic [4:0] adc_sleep,
  output logic [7:0] filter_ctl,
  output logic [3:0] vert_threshold_ctl,
  output logic [7:0] missing_sync_count
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  vdcs_pkg::vdcs_state_type st_r;
  vdcs_pkg::vdcs_state_type st_nxt;
  vdcs_pkg::vdcs_apb_req_type req;
  logic [7:0] status_byte;
  logic [2:0] std_sel;
  logic shadow_on;
  logic sel_50;
  logic sel_pal;
  logic sel_secam;
  logic [9:0] vact_view;
  logic [9:0] hdly_view;
  logic [7:0] rd_byte;
  logic access;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wb;

  // bus request gathered into one carrier
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign idx = {2'h0, req.paddr[7:2]};
  assign wb = req.pwdata[7:0];
  assign access = req.psel & req.penable;
  assign wr = access & req.pwrite;

  // status byte straight from the decoder core
  assign status_byte = {core_status.video_absent,
                        core_status.horiz_loop_locked,
                        core_status.subcarrier_locked,
                        core_status.field_even,
                        core_status.vertical_locked,
                        1'b0,
                        core_status.no_burst_flag,
                        core_status.fifty_hz_flag};

  // shadow bank selection by the programmed standard
  assign std_sel = st_r.stdsel[2:0];
  assign shadow_on = ~st_r.stdsel[`VDCS_STD_SHADOW_OFF];
  assign sel_50 = shadow_on & (std_sel == `VDCS_STD_PAL || std_sel == `VDCS_STD_SECAM ||
                               std_sel == `VDCS_STD_PALCN);
  assign sel_pal = shadow_on & (std_sel == `VDCS_STD_PAL || std_sel == `VDCS_STD_PALM ||
                                std_sel == `VDCS_STD_PALCN || std_sel == `VDCS_STD_PAL60);
  assign sel_secam = shadow_on & (std_sel == `VDCS_STD_SECAM);
  assign vact_view = sel_50 ? st_r.vact_50 : st_r.vact;
  assign hdly_view = sel_secam ? st_r.hdly_secam : (sel_pal ? st_r.hdly_pal : st_r.hdly);

  // read multiplexer
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      `VDCS_IDX_IDENT: rd_byte = {PRODUCT_CODE, REVISION};
      `VDCS_IDX_STATUS: rd_byte = status_byte;
      `VDCS_IDX_INPUT_FORMAT: rd_byte = st_r.input_format;
      `VDCS_IDX_KILLER: rd_byte = st_r.killer;
      `VDCS_IDX_ANALOG: rd_byte = {1'b0, st_r.analog[6:0]};
      `VDCS_IDX_CROP: rd_byte = {st_r.vdly_hi, vact_view[9:8], hdly_view[9:8], st_r.hact_hi};
      `VDCS_IDX_VDLY: rd_byte = st_r.vdly_lo;
      `VDCS_IDX_VACT: rd_byte = vact_view[7:0];
      `VDCS_IDX_HDLY: rd_byte = hdly_view[7:0];
      `VDCS_IDX_HACT: rd_byte = st_r.hact_lo;
      `VDCS_IDX_FILT: rd_byte = st_r.filt;
      `VDCS_IDX_STDSEL: rd_byte = st_r.stdsel;
      `VDCS_IDX_MISC: rd_byte = st_r.misc;
      default: rd_byte = 8'h00;
    endcase
  end

  // next state: bus writes, restart sequence and derived outputs
  always_comb begin
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (req.psel & ~req.penable) begin
      st_nxt.pready = 1'b1; // answer in the access cycle
      st_nxt.pslverr = (idx > `VDCS_IDX_LAST);
      st_nxt.prdata = req.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
    if (wr & st_r.pready & ~st_r.pslverr) begin
      unique case (idx)
        `VDCS_IDX_INPUT_FORMAT: st_nxt.input_format = wb;
        `VDCS_IDX_KILLER: st_nxt.killer = wb;
        `VDCS_IDX_ANALOG: begin
          st_nxt.analog = {1'b0, wb[6:0]};
          if (wb[`VDCS_AN_RESTART]) begin
            st_nxt.phase = vdcs_pkg::VDCS_RESTART;
            st_nxt.restart_cnt = `VDCS_RESTART_CYCLES;
          end
        end
        `VDCS_IDX_CROP: begin
          st_nxt.vdly_hi = wb[7:6];
          st_nxt.hact_hi = wb[1:0];
          if (sel_50) st_nxt.vact_50[9:8] = wb[5:4];
          else st_nxt.vact[9:8] = wb[5:4];
          if (sel_secam) st_nxt.hdly_secam[9:8] = wb[3:2];
          else if (sel_pal) st_nxt.hdly_pal[9:8] = wb[3:2];
          else st_nxt.hdly[9:8] = wb[3:2];
        end
        `VDCS_IDX_VDLY: st_nxt.vdly_lo = wb;
        `VDCS_IDX_VACT: begin
          if (sel_50) st_nxt.vact_50[7:0] = wb;
          else st_nxt.vact[7:0] = wb;
        end
        `VDCS_IDX_HDLY: begin
          if (sel_secam) st_nxt.hdly_secam[7:0] = wb;
          else if (sel_pal) st_nxt.hdly_pal[7:0] = wb;
          else st_nxt.hdly[7:0] = wb;
        end
        `VDCS_IDX_HACT: st_nxt.hact_lo = wb;
        `VDCS_IDX_FILT: st_nxt.filt = wb;
        `VDCS_IDX_STDSEL: st_nxt.stdsel = wb;
        `VDCS_IDX_MISC: st_nxt.misc = wb;
        default: st_nxt.gain = st_r.gain;
      endcase
    end
    // soft restart: core held in default state, registers kept
    unique case (st_r.phase)
      vdcs_pkg::VDCS_RUN: st_nxt.core_restart = 1'b0;
      vdcs_pkg::VDCS_RESTART: begin
        st_nxt.core_restart = 1'b1;
        st_nxt.restart_cnt = st_r.restart_cnt - 4'h1;
        if (st_r.restart_cnt == 4'h1) st_nxt.phase = vdcs_pkg::VDCS_SETTLE;
      end
      vdcs_pkg::VDCS_SETTLE: begin
        st_nxt.core_restart = 1'b0;
        st_nxt.phase = vdcs_pkg::VDCS_RUN;
      end
    endcase
    st_nxt.gain_loop_run = ~st_r.analog[`VDCS_AN_GAINOFF];
    st_nxt.gain_applied = st_r.analog[`VDCS_AN_GAINOFF] ? st_r.gain : 9'h000;
    st_nxt.sleep_vec = {st_r.analog[5], st_r.analog[3:0]};
    st_nxt.window.vert_delay_lines = {st_r.vdly_hi, st_r.vdly_lo};
    st_nxt.window.vert_active_lines = core_status.fifty_hz_flag & shadow_on ? st_r.vact_50 : st_r.vact;
    st_nxt.window.horiz_delay_pixels = hdly_view;
    st_nxt.window.horiz_active_pixels = {st_r.hact_hi, st_r.hact_lo};
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.input_format <= `VDCS_RST_INPUT_FORMAT;
      st_r.killer <= `VDCS_RST_KILLER;
      st_r.analog <= `VDCS_RST_ANALOG;
      st_r.filt <= `VDCS_RST_FILT;
      st_r.stdsel <= `VDCS_RST_STDSEL;
      st_r.misc <= `VDCS_RST_MISC;
      st_r.gain <= `VDCS_RST_GAIN;
      st_r.vdly_lo <= `VDCS_RST_VDLY;
      st_r.vact <= {2'h1, `VDCS_RST_VACT};
      st_r.vact_50 <= {2'h1, `VDCS_RST_VACT};
      st_r.hdly <= {2'h0, `VDCS_RST_HDLY};
      st_r.hdly_pal <= {2'h0, `VDCS_RST_HDLY};
      st_r.hdly_secam <= {2'h0, `VDCS_RST_HDLY};
      st_r.hact_hi <= 2'h2;
      st_r.hact_lo <= `VDCS_RST_HACT;
      st_r.phase <= vdcs_pkg::VDCS_RUN;
      st_r.gain_loop_run <= 1'b1;
      st_r.window <= '{vert_delay_lines: 10'h012, vert_active_lines: 10'h120,
                       horiz_delay_pixels: 10'h010, horiz_active_pixels: 10'h2d0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs from the state register
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign crop_window = st_r.window;
  assign xtal_freq_sel = st_r.input_format[6];
  assign decode_input_type = st_r.input_format[5:4];
  assign luma_source_sel = st_r.input_format[3:2];
  assign killer_time_const = st_r.killer[6:5];
  assign core_restart = st_r.core_restart;
  assign gain_loop_run = st_r.gain_loop_run;
  assign fixed_gain_value = st_r.gain_applied;
  assign adc_sleep = st_r.sleep_vec;
  assign filter_ctl = st_r.filt;
  assign vert_threshold_ctl = st_r.misc[3:0];
  assign missing_sync_count = {2'h0, st_r.misc[7:2]};
endmodule // vdcs_regs

// [tb/tb_top.sv]
// self-checking bench for the decoder control register bank
`timescale 1ns/100ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
  logic xtal_freq_sel, core_restart, gain_loop_run, present, even, burst, fifty;
  logic [7:0] paddr, rd, filter_ctl, missing_sync_count;
  logic [31:0] pwdata, prdata;
  logic [1:0] decode_input_type, luma_source_sel, killer_time_const;
  logic [8:0] fixed_gain_value;
  logic [4:0] adc_sleep;
  logic [3:0] vert_threshold_ctl;
  vdcs_pkg::vdcs_status_type core_status;
  vdcs_pkg::vdcs_window_type crop_window;
  int err_total, comparisons, cyc;
  logic [31:0] rows [14];
  logic [11:0] scn [3];
  // ----------------------------------------------------------------
  // clock, source model and design
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  vdcs_video_src SRC (.pclk, .presetn, .present, .even, .burst, .fifty, .status(core_status));
  vdcs_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .core_status, .crop_window, .xtal_freq_sel, .decode_input_type, .luma_source_sel, .killer_time_const,
    .core_restart, .gain_loop_run, .fixed_gain_value, .adc_sleep, .filter_ctl, .vert_threshold_ctl,
    .missing_sync_count);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk($sformatf("register %h", a), rd, exp);
  endtask
  task automatic settle;
    repeat (2) @(negedge pclk);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {present, even, burst, fifty} = 4'hd;
    rows = '{32'h00ffaaaa, 32'h083c403c, 32'h10600060, 32'h0cff0000, 32'h143c0000, 32'h183f403f,
      32'h1ce412e4, 32'h205a125a, 32'h24332033, 32'h28441044, 32'h2c77d077, 32'h30f6ccf6,
      32'h340f0f0f, 32'h38a444a4};
    scn = '{12'hf79, 12'h280, 12'h84a};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      rdchk(rows[i][31:24], rows[i][15:8]);
      apb(1'b1, rows[i][31:24], rows[i][23:16]);
      rdchk(rows[i][31:24], rows[i][7:0]);
    end
    settle();
    chk("killer", killer_time_const, 2'h3);
    chk("filter", filter_ctl, 8'hf6);
    chk("sleep", adc_sleep, 5'h1f);
    chk("gain", {gain_loop_run, fixed_gain_value}, 10'h0f0);
    chk("window", crop_window, {10'h35a, 10'h233, 10'h144, 10'h077});
    chk("miss count", missing_sync_count, 8'h29);
    chk("threshold", vert_threshold_ctl, 4'h4);
    $display("register table test done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h08, {1'b0, i[0], i[1:0], i[1:0], 2'b00});
      settle();
      chk("format", {xtal_freq_sel, decode_input_type, luma_source_sel}, {i[0], i[1:0], i[1:0]});
    end
    apb(1'b1, 8'h18, 8'haf);
    settle();
    chk("restart", core_restart, 1'b1);
    rdchk(8'h18, 8'h2f);
    rdchk(8'h1c, 8'he4);
    chk("restart end", core_restart, 1'b0);
    chk("gain", {gain_loop_run, fixed_gain_value}, 10'h200);
    $display("format and restart test done");
    foreach (scn[i]) begin
      {present, even, burst, fifty} <= scn[i][11:8];
      repeat (12) @(posedge pclk);
      rdchk(8'h04, scn[i][7:0]);
    end
    apb(1'b1, 8'h04, 8'hff);
    rdchk(8'h04, 8'h4a);
    apb(1'b0, 8'h3c, 8'h00);
    chk("slave error", slverr, 1'b1);
    $display("status test done");
    apb(1'b1, 8'h34, 8'h01);
    apb(1'b1, 8'h24, 8'h99);
    apb(1'b1, 8'h28, 8'h88);
    apb(1'b1, 8'h34, 8'h02);
    apb(1'b1, 8'h28, 8'h66);
    rdchk(8'h28, 8'h66);
    rdchk(8'h24, 8'h99);
    apb(1'b1, 8'h34, 8'h00);
    rdchk(8'h24, 8'h33);
    rdchk(8'h28, 8'h44);
    apb(1'b1, 8'h34, 8'h01);
    rdchk(8'h28, 8'h88);
    apb(1'b1, 8'h34, 8'h05);
    rdchk(8'h24, 8'h99);
    rdchk(8'h28, 8'h88);
    apb(1'b1, 8'h34, 8'h06);
    rdchk(8'h24, 8'h33);
    apb(1'b1, 8'h34, 8'h09);
    rdchk(8'h28, 8'h44);
    $display("shadow test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(8'h20, 8'h12);
    rdchk(8'h2c, 8'hd0);
    rdchk(8'h1c, 8'h12);
    $display("second reset test done");
    end_of_test();
  end
endmodule // tb_top

// [tb/vdcs_regs_properties.sv]
// concurrent checks on the ports of the decoder control bank
`timescale 1ns/100ps
module vdcs_regs_chk #(
  parameter logic [4:0] PRODUCT_CODE = 5'h15, // arbitrary value
  parameter logic [2:0] REVISION = 3'h2 // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire vdcs_pkg::vdcs_status_type core_status,
  input wire logic core_restart,
  input wire logic gain_loop_run,
  input wire logic [8:0] fixed_gain_value
);
  logic [6:0] st_q;
  // status as it stood when the read was set up
  always_ff @(posedge pclk) st_q <= core_status;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence restart_wr_s;
    pready && pwrite && paddr == 8'h18 && pwdata[7];
  endsequence
  sequence restart_run_s;
    core_restart [*4] ##1 !core_restart;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_on_unmapped: assert property (pready |-> pslverr == (paddr[7:2] > 6'h0e))
    else $error("slave error does not match address");
  a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_ident_value: assert property (pready && !pwrite && paddr == 8'h00 |->
    prdata[7:0] == {PRODUCT_CODE, REVISION}) else $error("identity value wrong");
  a_status_value: assert property (pready && !pwrite && paddr == 8'h04 |->
    prdata[7:0] == {st_q[6:2], 1'b0, st_q[1:0]}) else $error("status value wrong");
  a_restart_pulse: assert property (restart_wr_s |-> ##2 restart_run_s)
    else $error("restart pulse not four cycles");
  a_restart_hidden: assert property (pready && !pwrite && paddr == 8'h18 |-> !prdata[7])
    else $error("restart bit reads back");
  a_gain_select: assert property (fixed_gain_value == (gain_loop_run ? 9'h0 : 9'h0f0))
    else $error("gain value does not follow loop state");
endmodule // vdcs_regs_chk

bind vdcs_regs vdcs_regs_chk #(.PRODUCT_CODE(PRODUCT_CODE), .REVISION(REVISION)) u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_status, .core_restart,
  .gain_loop_run, .fixed_gain_value);

// [tb/vdcs_video_src.sv]
// model of the analog video source seen through the decoder core status
`timescale 1ns/100ps
module vdcs_video_src #(
  parameter logic [3:0] LOCK_CYC = 4'h8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic present,
  input wire logic even,
  input wire logic burst,
  input wire logic fifty,
  output vdcs_pkg::vdcs_status_type status
);
  logic [3:0] lock_cnt_r;
  logic locked;
  // loops need some lines of signal before they lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lock_cnt_r <= 4'h0;
    else if (!present) lock_cnt_r <= 4'h0; // lock lost with the signal
    else if (lock_cnt_r != LOCK_CYC) lock_cnt_r <= lock_cnt_r + 4'h1;
  end
  assign locked = lock_cnt_r == LOCK_CYC;
  // status flags as the core reports them
  assign status = {!present, locked, locked & burst, even, locked, !burst, fifty};
endmodule // vdcs_video_src
